// file: adi_pkg.sv
// constants shared by the audio dac serial interface
package adi_pkg;
  localparam int SAMPLE_W = 16;
  localparam logic [1:0] OVS_RSVD = 2'h0;
  localparam logic [1:0] OVS_128 = 2'h1;
  localparam logic [1:0] OVS_256 = 2'h2;
  localparam logic [1:0] OVS_384 = 2'h3;
  localparam logic [8:0] RATIO_128 = 9'h080;
  localparam logic [8:0] RATIO_256 = 9'h100;
  localparam logic [8:0] RATIO_384 = 9'h180;
  localparam logic [5:0] SLOTS_16 = 6'h10;
  localparam logic [5:0] SLOTS_32 = 6'h20;
  localparam logic [4:0] JUST_MSB = 5'h00;
  localparam logic [4:0] JUST_I2S = 5'h01;
  localparam logic [4:0] JUST_LSB = 5'h10;
  localparam logic [3:0] ADDR_CONTROL0 = 4'h0;
  localparam logic [3:0] ADDR_CONTROL1 = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam int C0_ENABLE = 0;
  localparam int C0_OVS_LO = 1;
  localparam int C0_SLOT = 3;
  localparam int C0_POL = 4;
  localparam logic [7:0] CONTROL0_RESET = 8'h00;
  localparam logic [7:0] CONTROL1_RESET = 8'h00;
endpackage

// file: adi_mclk_div.sv
// divider that turns system clock into oversampling clock enables
`timescale 1ns/100ps
module adi_mclk_div #(
  parameter int HALF_DIV = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tick
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic next_tick;

  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = 8'h00;
    end else if (cnt == 8'(HALF_DIV - 1)) begin
      next_cnt = 8'h00;
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt <= 8'h00;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

// file: adi_serial_out.sv
// stereo serialiser for an external dac, pcm and i2s formats
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/100ps
module adi_serial_out (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [15:0] LEFT_SAMPLE,
  input wire logic [15:0] RIGHT_SAMPLE,
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  output logic OVERSAMPLE_CLK_OUT,
  output logic BIT_CLK_OUT,
  output logic WORD_SELECT_OUT,
  output logic SDATA_OUT
);
  logic [7:0] dac_if_control0;
  logic [7:0] dac_if_control1;
  logic [7:0] next_control0;
  logic [7:0] next_control1;
  logic [7:0] next_rdata;
  logic dac_if_enable;
  logic [1:0] oversample_ratio_sel;
  logic slot_width_sel;
  logic word_select_polarity;
  logic [4:0] justify_shift;
  logic mtick;
  logic [8:0] ocnt;
  logic [8:0] next_ocnt;
  logic [5:0] slot;
  logic [5:0] next_slot;
  logic chan;
  logic next_chan;
  logic ovs;
  logic next_ovs;
  logic bck;
  logic next_bck;
  logic ws;
  logic next_ws;
  logic sd;
  logic next_sd;
  logic [15:0] lhold;
  logic [15:0] rhold;
  logic [15:0] next_lhold;
  logic [15:0] next_rhold;
  logic rdy;
  logic next_rdy;
  logic underrun;
  logic next_underrun;
  logic [8:0] ratio;
  logic [5:0] nslots;
  logic [8:0] half_bit;
  logic running;

  assign dac_if_enable = dac_if_control0[adi_pkg::C0_ENABLE];
  assign oversample_ratio_sel =
    dac_if_control0[adi_pkg::C0_OVS_LO +: 2];
  assign slot_width_sel = dac_if_control0[adi_pkg::C0_SLOT];
  assign word_select_polarity = dac_if_control0[adi_pkg::C0_POL];
  assign justify_shift = dac_if_control1[4:0];
  // reserved ratio keeps the link idle rather than guess a rate
  assign running = dac_if_enable &&
    (oversample_ratio_sel != adi_pkg::OVS_RSVD);

  // one mclk per two system cycles: the oversampling clock toggles per tick
  adi_mclk_div #(.HALF_DIV(1)) u_div (
    .clk(MCLK),
    .rst_n(RESET_N),
    .run(running),
    .tick(mtick)
  );

  function automatic logic [8:0] ratio_of(input logic [1:0] sel);
    unique case (sel)
      adi_pkg::OVS_128: ratio_of = adi_pkg::RATIO_128;
      adi_pkg::OVS_384: ratio_of = adi_pkg::RATIO_384;
      default: ratio_of = adi_pkg::RATIO_256;
    endcase
  endfunction

  always_comb begin
    ratio = ratio_of(oversample_ratio_sel);
    nslots = slot_width_sel ? adi_pkg::SLOTS_32 : adi_pkg::SLOTS_16;
    // oversample periods per bit: ratio / (2 * slots), half of that per edge
    half_bit = slot_width_sel ? (ratio >> 7) : (ratio >> 6);
  end

  // picks the bit shown at a given slot of a channel
  function automatic logic bit_at(input logic [15:0] s,
                                  input logic [5:0] pos,
                                  input logic [4:0] sh);
    logic [6:0] idx;
    idx = 7'(pos) - 7'(sh);
    if (pos < 6'(sh) || idx >= 7'(adi_pkg::SAMPLE_W)) begin
      bit_at = 1'b0;
    end else begin
      bit_at = s[4'(7'(adi_pkg::SAMPLE_W - 1) - idx)];
    end
  endfunction

  always_comb begin
    next_control0 = dac_if_control0;
    next_control1 = dac_if_control1;
    next_rdata = 8'h00;
    if (WR && ADDR == adi_pkg::ADDR_CONTROL0) begin
      next_control0 = WDATA;
    end
    if (WR && ADDR == adi_pkg::ADDR_CONTROL1) begin
      next_control1 = {3'h0, WDATA[4:0]};
    end
    if (RD) begin
      unique case (ADDR)
        adi_pkg::ADDR_CONTROL0: next_rdata = {3'h0, dac_if_control0[4:0]};
        adi_pkg::ADDR_CONTROL1: next_rdata = dac_if_control1;
        adi_pkg::ADDR_STATUS: next_rdata = {6'h00, underrun, chan};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_comb begin
    next_ocnt = ocnt;
    next_slot = slot;
    next_chan = chan;
    next_ovs = ovs;
    next_bck = bck;
    next_ws = ws;
    next_sd = sd;
    next_lhold = lhold;
    next_rhold = rhold;
    next_rdy = rdy;
    next_underrun = underrun;
    if (SAMPLE_VALID && rdy) begin
      next_rdy = 1'b0;
    end
    if (RD && ADDR == adi_pkg::ADDR_STATUS) begin
      next_underrun = 1'b0;
    end
    if (!running) begin
      next_ocnt = 9'h000;
      next_slot = 6'h00;
      next_chan = 1'b0;
      next_ovs = 1'b0;
      next_bck = 1'b0;
      next_ws = word_select_polarity;
      next_sd = 1'b0;
      next_rdy = 1'b1;
    end else if (mtick) begin
      next_ovs = ~ovs;
      if (ovs) begin
        if (ocnt == half_bit - 9'h001) begin
          next_ocnt = 9'h000;
          next_bck = ~bck;
          if (bck) begin
            // falling bit clock edge: advance slot and update data
            if (slot == nslots - 6'h01) begin
              next_slot = 6'h00;
              next_chan = ~chan;
              if (chan) begin
                // accepted since the last load, or offered right now
                if (SAMPLE_VALID || !rdy) begin
                  next_lhold = LEFT_SAMPLE;
                  next_rhold = RIGHT_SAMPLE;
                end else begin
                  next_lhold = 16'h0000;
                  next_rhold = 16'h0000;
                  next_underrun = 1'b1;
                end
                next_rdy = 1'b1;
              end
            end else begin
              next_slot = slot + 6'h01;
            end
            next_ws = next_chan ^ ~word_select_polarity;
            next_sd = bit_at(next_chan ? next_rhold : next_lhold,
                             next_slot, justify_shift);
          end
        end else begin
          next_ocnt = ocnt + 9'h001;
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RESET_N) begin
      dac_if_control0 <= adi_pkg::CONTROL0_RESET;
      dac_if_control1 <= adi_pkg::CONTROL1_RESET;
      RDATA <= 8'h00;
      ocnt <= 9'h000;
      slot <= 6'h00;
      chan <= 1'b0;
      ovs <= 1'b0;
      bck <= 1'b0;
      ws <= 1'b0;
      sd <= 1'b0;
      lhold <= 16'h0000;
      rhold <= 16'h0000;
      rdy <= 1'b0;
      underrun <= 1'b0;
    end else begin
      dac_if_control0 <= next_control0;
      dac_if_control1 <= next_control1;
      RDATA <= next_rdata;
      ocnt <= next_ocnt;
      slot <= next_slot;
      chan <= next_chan;
      ovs <= next_ovs;
      bck <= next_bck;
      ws <= next_ws;
      sd <= next_sd;
      lhold <= next_lhold;
      rhold <= next_rhold;
      rdy <= next_rdy;
      underrun <= next_underrun;
    end
  end

  assign SAMPLE_READY = rdy;
  assign OVERSAMPLE_CLK_OUT = ovs;
  assign BIT_CLK_OUT = bck;
  assign WORD_SELECT_OUT = ws;
  assign SDATA_OUT = sd;
endmodule

// file: adi_serial_out_asserts.sv
// port assertions for the audio dac serial interface
`timescale 1ns/100ps
module adi_serial_out_asserts (
  input wire logic MCLK,
  input wire logic RESET_N,
  input wire logic [3:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic OVERSAMPLE_CLK_OUT,
  input wire logic BIT_CLK_OUT,
  input wire logic WORD_SELECT_OUT,
  input wire logic SDATA_OUT
);
  logic run;
  logic pol;
  default clocking @(posedge MCLK);
  endclocking
  default disable iff (!RESET_N);
  // mirror of running (enable with a non-reserved ratio) and polarity, as written over the bus
  always_ff @(posedge MCLK)
    if (!RESET_N) {run, pol} <= 2'h0;
    else if (WR && ADDR == 4'h0) {run, pol} <= {WDATA[0] && |WDATA[2:1], WDATA[4]};
  a_link_idle: assert property (!run [*8] |->
    !OVERSAMPLE_CLK_OUT && !BIT_CLK_OUT && !SDATA_OUT) else $error("idle link");
  a_ovs_toggle: assert property (run [*4] |->
    OVERSAMPLE_CLK_OUT != $past(OVERSAMPLE_CLK_OUT)) else $error("ovs stuck");
  a_ws_idle: assert property (!run [*8] |->
    WORD_SELECT_OUT == pol) else $error("idle ws level");
  a_ws_on_fall: assert property (run && $past(run) &&
    $changed(WORD_SELECT_OUT) |-> $fell(BIT_CLK_OUT)) else $error("ws edge");
  a_sd_on_fall: assert property (run && $past(run) &&
    $changed(SDATA_OUT) |-> $fell(BIT_CLK_OUT)) else $error("data edge");
  a_bclk_high: assert property ($rose(BIT_CLK_OUT) && run |->
    BIT_CLK_OUT [*2]) else $error("bit clock high too short");
  a_rdata_idle: assert property (!$past(RD) |-> RDATA == 8'h00)
    else $error("read data outside slot");
  a_rd_unmapped: assert property (RD && ADDR > 4'h2 |=> RDATA == 8'h00)
    else $error("unmapped read");
  a_ctl_pad: assert property (RD && ADDR == 4'h0 |=> RDATA[7:5] == 3'h0)
    else $error("control pad bits");
  cover property (run [*8]);
  cover property ($fell(WORD_SELECT_OUT));
  cover property (RD && ADDR > 4'h2);
endmodule
bind adi_serial_out adi_serial_out_asserts i_chk (.MCLK, .RESET_N, .ADDR,
  .WDATA, .WR, .RD, .RDATA, .OVERSAMPLE_CLK_OUT, .BIT_CLK_OUT,
  .WORD_SELECT_OUT, .SDATA_OUT);

// file: adi_dac_model.sv
// behavioural external dac that collects each channel word
`timescale 1ns/100ps
module adi_dac_model (
  input wire logic clk,
  input wire logic bclk,
  input wire logic ws,
  input wire logic sd,
  output logic [31:0] word,
  output logic [5:0] nbits,
  output logic [9:0] ncyc,
  output logic chan_ws,
  output logic stb
);
  logic bclk_q = 1'h0;
  logic ws_q = 1'h0;
  logic [31:0] sr = '0;
  logic [5:0] cnt = '0;
  logic [9:0] cyc = '0;
  initial stb = 1'h0;
  // sample on the rising bit clock; a new ws level opens a channel
  always @(posedge clk) begin
    bclk_q <= bclk;
    cyc <= cyc + 10'h1;
    stb <= 1'h0;
    if (bclk && !bclk_q) begin
      sr <= {sr[30:0], sd};
      cnt <= cnt + 6'h1;
      if (ws !== ws_q) begin
        word <= sr;
        nbits <= cnt;
        ncyc <= cyc;
        chan_ws <= ws_q;
        stb <= 1'h1;
        sr <= {31'h0, sd};
        cnt <= 6'h1;
        cyc <= 10'h1;
        ws_q <= ws;
      end
    end
  end
endmodule

// file: adi_serial_out_tb.sv
// self-checking bench for the audio dac serial interface
`timescale 1ns/100ps
module adi_serial_out_tb;
  logic MCLK = 1'h0;
  logic RESET_N = 1'h0;
  logic WR = 1'h0;
  logic RD = 1'h0;
  logic SAMPLE_VALID = 1'h0;
  logic [3:0] ADDR = '0;
  logic [7:0] WDATA = '0;
  logic [15:0] LEFT_SAMPLE = '0;
  logic [15:0] RIGHT_SAMPLE = '0;
  logic [7:0] RDATA;
  logic SAMPLE_READY, OVERSAMPLE_CLK_OUT, BIT_CLK_OUT, WORD_SELECT_OUT;
  logic SDATA_OUT, chan_ws, stb;
  logic [31:0] word;
  logic [5:0] nbits;
  logic [9:0] ncyc;
  int n_fail = 0;
  int compares = 0;
  // {shift, polarity, 32 slots, ratio}: every ratio, msb, i2s, lsb, 18 bit
  localparam logic [8:0] CFG [6] = '{9'h005, 9'h00A, 9'h01F, 9'h105,
    9'h0E6, 9'h011};
  always #50 MCLK = ~MCLK;
  adi_serial_out i_dut (.MCLK, .RESET_N, .ADDR, .WDATA, .WR, .RD, .RDATA,
    .LEFT_SAMPLE, .RIGHT_SAMPLE, .SAMPLE_VALID, .SAMPLE_READY,
    .OVERSAMPLE_CLK_OUT, .BIT_CLK_OUT, .WORD_SELECT_OUT, .SDATA_OUT);
  adi_dac_model i_dac (.clk(MCLK), .bclk(BIT_CLK_OUT), .ws(WORD_SELECT_OUT),
    .sd(SDATA_OUT), .word, .nbits, .ncyc, .chan_ws, .stb);
  task automatic test_done;
    if (n_fail == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'h1;
    @(posedge MCLK);
    WR <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'h1;
    @(posedge MCLK);
    RD <= 1'h0;
    @(negedge MCLK);
    d = RDATA;
  endtask
  // strobe lasts one cycle, so look at every falling edge
  task automatic wait_stb;
    for (int i = 0; i < 3000; i++) begin
      @(negedge MCLK);
      if (stb === 1'h1) return;
    end
    n_fail++;
    $display("mismatch %0t no channel word", $time);
    test_done;
  endtask
  initial begin
    logic [7:0] d;
    logic [8:0] c;
    logic [15:0] s, e;
    repeat (2) @(posedge MCLK);
    RESET_N <= 1'h1;
    rd(4'h0, d);
    check(d, '0);
    wr(4'h7, 8'hFF);
    rd(4'h7, d);
    check(d, '0);
    wr(4'h0, 8'h01);
    repeat (20) @(negedge MCLK);
    check({OVERSAMPLE_CLK_OUT, BIT_CLK_OUT}, '0);
    check(SAMPLE_READY, 1'h1);
    foreach (CFG[k]) begin
      c = CFG[k];
      s = {1'h1, c[6:0], 7'h5A, 1'h1};
      @(posedge MCLK);
      LEFT_SAMPLE <= s;
      RIGHT_SAMPLE <= s ^ 16'h7FFE;
      SAMPLE_VALID <= 1'h1;
      wr(4'h0, 8'h00);
      wr(4'h1, {3'h0, c[8:4]});
      wr(4'h0, {3'h0, c[3:0], 1'h1});
      // start-up glitches and stale holds may give up to four early words
      repeat (4) wait_stb;
      repeat (2) begin
        wait_stb;
        // left channel sits at the inverse of the polarity bit
        e = (chan_ws !== c[3]) ? s : s ^ 16'h7FFE;
        check(word, ({e, 16'h0} >> c[8:4]) >> (c[2] ? 0 : 16));
        check(nbits, c[2] ? 32 : 16);
        check(ncyc, {c[1:0], 7'h0});
        check(SAMPLE_READY, 1'h0);
      end
    end
    @(posedge MCLK);
    SAMPLE_VALID <= 1'h0;
    repeat (6) wait_stb;
    check(word, '0);
    rd(4'h2, d);
    check(d[1], 1'h1);
    test_done;
  end
endmodule
